// ===== pbpm_pkg.sv
// ==========================================================
// shared constants and types for the power manager
package pbpm_pkg;
    // ======================================================
    // clock and timing
    localparam int unsigned CLK_HZ = 20_000_000;      // system clock rate
    localparam int unsigned CLK_PER_US = CLK_HZ / 1_000_000;
    localparam int unsigned L0S_IDLE_NS = 6000;       // idle time before standby, 6 us
    // least time, so round up
    localparam int unsigned L0S_IDLE_CYC = (L0S_IDLE_NS * CLK_PER_US + 999) / 1000;
    localparam int unsigned PME_SAMPLE_US = 100;      // pme pin sampling period
    localparam int unsigned PME_SAMPLE_CYC = PME_SAMPLE_US * CLK_PER_US;
    localparam int unsigned CNT_W = 12;               // wide enough for both counts
    localparam logic [CNT_W-1:0] L0S_IDLE_MAX = CNT_W'(L0S_IDLE_CYC);
    // handshake lengths with the physical layer
    localparam int unsigned HS_W = 4;
    localparam logic [HS_W-1:0] L0S_EXIT_LAST = 4'h3; // standby exit, 4 cycles
    localparam logic [HS_W-1:0] L1_HS_LAST = 4'h7;    // l1 entry or exit, 8 cycles
    // ======================================================
    // software fields
    localparam logic [1:0] PSF_D0 = 2'h0;             // power state field: d0
    localparam logic [1:0] PSF_D3HOT = 2'h3;          // power state field: d3hot
    localparam int unsigned LSE_L0S_BIT = 0;          // standby enable bit position
    // ======================================================
    // secondary bus
    localparam int unsigned SEC_CLK_N = 5;            // number of secondary clocks
    // ======================================================
    // state types
    typedef enum logic [2:0] {
        LNK_L0, LNK_L0S, LNK_L0S_EXIT, LNK_L1_ENTRY, LNK_L1, LNK_L1_EXIT, LNK_L23
    } pbpm_link_t;
    typedef enum logic [1:0] {
        DEV_D0_UNINIT, DEV_D0_ACTIVE, DEV_D3_HOT, DEV_D3_COLD
    } pbpm_dev_t;
endpackage : pbpm_pkg

// ===== pbpm_pme_sampler.sv
`timescale 1ns/1ns
// ==========================================================
// pme pin synchroniser and periodic sampler
module pbpm_pme_sampler #(
    parameter int unsigned SAMPLE_CYC = pbpm_pkg::PME_SAMPLE_CYC
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // asynchronous pin, active low
    input wire logic pme_pin_n_in,
    // sampled result
    output logic tick_out,
    output logic pme_level_out
);
    import pbpm_pkg::*;
    localparam logic [CNT_W-1:0] LAST = CNT_W'(SAMPLE_CYC - 1);
    logic s1_r, s2_r, s3_r; // three stage synchroniser
    logic stable_r; // accepted pin level
    logic [CNT_W-1:0] cnt_r; // sample period counter
    logic [CNT_W-1:0] gap_r; // helper: cycles since last tick
    logic seen_r; // helper: a tick has happened
    // ======================================================
    // synchroniser: a change counts once stages two and three agree
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            s1_r <= 1'b1;
            s2_r <= 1'b1;
            s3_r <= 1'b1;
            stable_r <= 1'b1;
        end else begin
            s1_r <= pme_pin_n_in;
            s2_r <= s1_r;
            s3_r <= s2_r;
            if (s2_r == s3_r) begin
                stable_r <= s3_r;
            end
        end
    end
    // ======================================================
    // sample once per period; the pin is otherwise ignored
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            cnt_r <= '0;
            tick_out <= 1'b0;
            pme_level_out <= 1'b0;
        end else begin
            tick_out <= (cnt_r == LAST); // RQ19
            cnt_r <= (cnt_r == LAST) ? '0 : cnt_r + 1'b1;
            if (cnt_r == LAST) begin
                pme_level_out <= ~stable_r; // RQ19
            end
        end
    end
    // helper counter for the period check
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            gap_r <= '0;
            seen_r <= 1'b0;
        end else begin
            gap_r <= tick_out ? '0 : gap_r + 1'b1;
            seen_r <= seen_r | tick_out;
        end
    end
    chk_sample_period: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ19
        tick_out && seen_r |-> gap_r == LAST)
        else $error("pme sample period wrong");
endmodule : pbpm_pme_sampler

// ===== pbpm_power_manager.sv
`timescale 1ns/1ns
// Behaviour
// RQ1 - standby entry off until software enables it
// RQ2 - enter standby after 6 us transmit idle
// RQ3 - pending packets start standby exit
// RQ4 - traffic from either side wakes the link
// RQ5 - no packets sent while in standby
// RQ6 - receive stays open during transmit standby
// RQ7 - active power management never enters L1
// RQ8 - writing D3hot starts L1 entry
// RQ9 - no packets exchanged in L1
// RQ10 - L1 exit by device or partner
// RQ11 - turn-off message answered, then L2/L3 ready
// RQ12 - no packets in L2/L3 ready
// RQ13 - D0 uninitialised until an enable is set
// RQ14 - D3hot still accepts configuration accesses
// RQ15 - no soft reset flag set on D0 return
// RQ16 - software writes only D0 or D3hot
// RQ17 - pme message posted toward root complex
// RQ18 - link returned to L0 before pme message
// RQ19 - pme input sampled every 100 us
// RQ20 - no pme message in D3cold
// RQ21 - D3hot keeps secondary clocks, reset, pme
// RQ22 - L2/L3 ready: secondary bus off, pme ignored
// RQ23 - D0 write in L1 starts L1 exit
module pbpm_power_manager #(
    parameter int unsigned SEC_CLK_W = pbpm_pkg::SEC_CLK_N,
    parameter int unsigned PME_SAMPLE_CYC = pbpm_pkg::PME_SAMPLE_CYC
) (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // software configuration and power removal
    input wire logic [1:0] power_state_field_in,
    input wire logic power_state_wr_in,
    input wire logic [1:0] link_standby_enable_field_in,
    input wire logic mem_space_en_in,
    input wire logic io_space_en_in,
    input wire logic bus_master_en_in,
    input wire logic power_removed_in,
    // traffic and link events
    input wire logic tx_pkt_pending_in,
    input wire logic tx_pkt_sent_in,
    input wire logic rx_tlp_in,
    input wire logic pci_side_req_in,
    input wire logic partner_l1_exit_in,
    input wire logic pme_turn_off_in,
    // secondary bus pin
    input wire logic secondary_pme_request_n_in,
    // state view
    output pbpm_pkg::pbpm_link_t link_state_out,
    output pbpm_pkg::pbpm_dev_t dev_state_out,
    output logic no_soft_reset_out,
    output logic config_accept_out,
    // packet gating and messages
    output logic tx_allow_out,
    output logic rx_accept_out,
    output logic pme_msg_out,
    output logic pme_to_ack_out,
    // secondary bus control
    output logic [SEC_CLK_W-1:0] secondary_clock_outputs_en_out,
    output logic secondary_bus_reset_n_out,
    output logic secondary_bus_enable_out
);
    import pbpm_pkg::*;

    // ======================================================
    // declarations
    pbpm_link_t link_r; // link power state
    pbpm_link_t link_nxt; // its next value
    pbpm_dev_t dev_r; // device power state
    logic no_soft_r; // no soft reset flag
    logic [CNT_W-1:0] idle_cnt_r; // transmit idle cycles
    logic [HS_W-1:0] hs_cnt_r; // physical handshake cycles
    logic pme_pend_r; // pme message waiting for L0
    logic toff_pend_r; // turn-off ack waiting for L0
    logic pme_prev_r; // pme level at previous sample
    logic tick; // sampler period pulse
    logic pme_level; // sampled pme request
    logic l0s_en; // software standby enable
    logic d0_write; // software moves d3hot to d0
    logic wake; // anything needing the link in L0
    logic want_l1; // d3hot with nothing to send
    logic l1_wake; // reason to leave L1
    logic send_pme; // pme message goes out now
    logic send_ack; // turn-off ack goes out now
    logic pme_edge; // new pme request at a sample
    logic pme_ok; // pme input is honoured

    // ======================================================
    // pme pin sampling
    pbpm_pme_sampler #(
        .SAMPLE_CYC(PME_SAMPLE_CYC)
    ) u_sampler (
        .sys_clk_in(sys_clk_in),
        .rst_n_in(rst_n_in),
        .pme_pin_n_in(secondary_pme_request_n_in),
        .tick_out(tick),
        .pme_level_out(pme_level)
    );

    // ======================================================
    // combinational decisions
    always_comb begin
        l0s_en = link_standby_enable_field_in[LSE_L0S_BIT]; // RQ1
        d0_write = power_state_wr_in && (power_state_field_in == PSF_D0)
            && (dev_r == DEV_D3_HOT);
        // pme only from powered states short of L2/L3 ready
        pme_ok = (dev_r != DEV_D3_COLD) && !power_removed_in // RQ20
            && (link_r != LNK_L23); // RQ22
        pme_edge = tick && pme_level && !pme_prev_r && pme_ok;
        // traffic from either side needs L0
        wake = tx_pkt_pending_in || rx_tlp_in || pci_side_req_in // RQ3 RQ4
            || pme_pend_r || toff_pend_r; // RQ18
        want_l1 = (dev_r == DEV_D3_HOT) && !pme_pend_r && !toff_pend_r
            && !tx_pkt_pending_in; // RQ7
        l1_wake = partner_l1_exit_in || pme_pend_r || toff_pend_r // RQ10
            || (dev_r != DEV_D3_HOT); // RQ23
        // the ack goes first; power removal makes a pme moot
        send_ack = (link_r == LNK_L0) && toff_pend_r; // RQ11
        send_pme = (link_r == LNK_L0) && pme_pend_r && !toff_pend_r; // RQ18
    end

    // ======================================================
    // link state: next value
    always_comb begin
        link_nxt = link_r;
        unique case (link_r)
            LNK_L0: begin
                if (send_ack) begin
                    link_nxt = LNK_L23; // RQ11
                end else if (want_l1) begin
                    link_nxt = LNK_L1_ENTRY; // RQ8
                end else if (l0s_en && (idle_cnt_r == L0S_IDLE_MAX) && !wake
                    && (dev_r != DEV_D3_HOT)) begin
                    link_nxt = LNK_L0S; // RQ2
                end
            end
            LNK_L0S: begin
                // transmitter only; the receiver is untouched
                if (want_l1) begin
                    link_nxt = LNK_L1_ENTRY;
                end else if (wake) begin
                    link_nxt = LNK_L0S_EXIT; // RQ3 RQ4
                end
            end
            LNK_L0S_EXIT: begin
                if (hs_cnt_r == L0S_EXIT_LAST) begin
                    link_nxt = LNK_L0;
                end
            end
            LNK_L1_ENTRY: begin
                // abort if software or an event changed its mind
                if (!want_l1) begin
                    link_nxt = LNK_L0;
                end else if (hs_cnt_r == L1_HS_LAST) begin
                    link_nxt = LNK_L1;
                end
            end
            LNK_L1: begin
                if (l1_wake) begin
                    link_nxt = LNK_L1_EXIT; // RQ10 RQ23
                end
            end
            LNK_L1_EXIT: begin
                if (hs_cnt_r == L1_HS_LAST) begin
                    link_nxt = LNK_L0;
                end
            end
            LNK_L23: begin
                // left only by reset once power returns
                link_nxt = LNK_L23;
            end
            default: begin
                link_nxt = LNK_L0;
            end
        endcase
    end

    // ======================================================
    // link state register
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            link_r <= LNK_L0;
        end else begin
            link_r <= link_nxt;
        end
    end

    // handshake counter restarts on every state change
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            hs_cnt_r <= '0;
        end else if (link_nxt != link_r) begin
            hs_cnt_r <= '0;
        end else if (hs_cnt_r != L1_HS_LAST) begin
            hs_cnt_r <= hs_cnt_r + 1'b1;
        end
    end

    // transmit idle time, only counted in L0
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            idle_cnt_r <= '0;
        end else if ((link_r != LNK_L0) || tx_pkt_sent_in || tx_pkt_pending_in) begin
            idle_cnt_r <= '0; // RQ2
        end else if (idle_cnt_r != L0S_IDLE_MAX) begin
            idle_cnt_r <= idle_cnt_r + 1'b1; // RQ2
        end
    end

    // ======================================================
    // device power state
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            dev_r <= DEV_D0_UNINIT; // RQ13
        end else if (power_removed_in) begin
            dev_r <= DEV_D3_COLD;
        end else if (dev_r != DEV_D3_COLD) begin
            // d1 and d2 writes are ignored: they are unsupported
            if (power_state_wr_in && (power_state_field_in == PSF_D3HOT)) begin
                dev_r <= DEV_D3_HOT; // RQ8 RQ16
            end else if (d0_write) begin
                dev_r <= DEV_D0_UNINIT; // RQ14
            end else if ((dev_r == DEV_D0_UNINIT)
                && (mem_space_en_in || io_space_en_in || bus_master_en_in)) begin
                dev_r <= DEV_D0_ACTIVE; // RQ13
            end
        end
    end

    // no soft reset flag, held until the next reset
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            no_soft_r <= 1'b0;
        end else if (d0_write) begin
            no_soft_r <= 1'b1; // RQ15
        end
    end

    // ======================================================
    // pending messages; a new event beats the clear
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            pme_pend_r <= 1'b0;
            pme_prev_r <= 1'b0;
        end else begin
            if (tick) begin
                pme_prev_r <= pme_level;
            end
            if (pme_edge) begin
                pme_pend_r <= 1'b1; // RQ19
            end else if (send_pme || !pme_ok) begin
                pme_pend_r <= 1'b0; // RQ20 RQ22
            end
        end
    end

    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            toff_pend_r <= 1'b0;
        end else if (pme_turn_off_in && (link_r != LNK_L23)) begin
            toff_pend_r <= 1'b1; // RQ11
        end else if (send_ack) begin
            toff_pend_r <= 1'b0;
        end
    end

    // ======================================================
    // registered outputs; gating uses the next state so it
    // matches the link state in every cycle
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            link_state_out <= LNK_L0;
            dev_state_out <= DEV_D0_UNINIT;
            no_soft_reset_out <= 1'b0;
            config_accept_out <= 1'b1;
            tx_allow_out <= 1'b1;
            rx_accept_out <= 1'b1;
            pme_msg_out <= 1'b0;
            pme_to_ack_out <= 1'b0;
        end else begin
            link_state_out <= link_nxt;
            dev_state_out <= dev_r;
            no_soft_reset_out <= no_soft_r;
            config_accept_out <= (dev_r != DEV_D3_COLD); // RQ14
            tx_allow_out <= (link_nxt == LNK_L0); // RQ5 RQ9 RQ12
            rx_accept_out <= (link_nxt == LNK_L0) || (link_nxt == LNK_L0S)
                || (link_nxt == LNK_L0S_EXIT); // RQ6
            pme_msg_out <= send_pme; // RQ17
            pme_to_ack_out <= send_ack; // RQ11
        end
    end

    // secondary bus follows device and link state
    always_ff @(posedge sys_clk_in) begin
        if (!rst_n_in) begin
            secondary_clock_outputs_en_out <= '1;
            secondary_bus_reset_n_out <= 1'b1;
            secondary_bus_enable_out <= 1'b0;
        end else if ((link_r == LNK_L23) || (dev_r == DEV_D3_COLD)) begin
            secondary_clock_outputs_en_out <= '0; // RQ22
            secondary_bus_reset_n_out <= 1'b0;
            secondary_bus_enable_out <= 1'b0;
        end else begin
            secondary_clock_outputs_en_out <= '1; // RQ21
            secondary_bus_reset_n_out <= 1'b1;
            secondary_bus_enable_out <= (dev_r != DEV_D3_HOT); // RQ21
        end
    end

    // ======================================================
    // checks
    chk_l0s_needs_enable: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ1
        (link_r == LNK_L0) ##1 (link_r == LNK_L0S) |-> $past(l0s_en))
        else $error("standby entered while disabled");
    chk_l0s_idle_time: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ2
        $rose(link_r == LNK_L0S) && $past(link_r == LNK_L0) |-> $past(idle_cnt_r) == L0S_IDLE_MAX)
        else $error("standby entered before idle time");
    chk_l0s_exit_pend: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ3
        (link_r == LNK_L0S) && tx_pkt_pending_in && !want_l1 |=> link_r == LNK_L0S_EXIT
        ##[4:4] link_r == LNK_L0)
        else $error("standby exit not started");
    chk_pci_wake: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ4
        (link_r == LNK_L0S) && pci_side_req_in && !want_l1 |=> link_r == LNK_L0S_EXIT)
        else $error("pci side request did not wake link");
    chk_tx_gated: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ5
        tx_allow_out |-> link_state_out == LNK_L0)
        else $error("transmit allowed outside L0");
    chk_l1_only_d3: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ7
        $rose(link_r == LNK_L1) |-> $past(dev_r) == DEV_D3_HOT)
        else $error("L1 reached outside d3hot");
    chk_d3_l1_entry: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ8
        (link_r == LNK_L0) && want_l1 && !toff_pend_r |=> (link_r == LNK_L1_ENTRY)
        ##8 (link_r == LNK_L1) || !want_l1)
        else $error("d3hot did not lead to L1");
    chk_l1_exit: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ10
        (link_r == LNK_L1) && partner_l1_exit_in |=> link_r == LNK_L1_EXIT ##8 link_r == LNK_L0)
        else $error("partner L1 exit not honoured");
    chk_turnoff_ack: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ11
        (link_r == LNK_L0) && toff_pend_r |=> (link_r == LNK_L23) && pme_to_ack_out)
        else $error("turn-off not acknowledged");
    chk_d0_active: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ13
        (dev_r == DEV_D0_UNINIT) && (mem_space_en_in || io_space_en_in || bus_master_en_in)
        && !power_state_wr_in && !power_removed_in |=> dev_r == DEV_D0_ACTIVE)
        else $error("enable did not activate d0");
    chk_no_soft_rst: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ15
        d0_write |-> ##2 no_soft_reset_out)
        else $error("no soft reset flag not set");
    chk_pme_in_l0: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ18
        pme_msg_out |-> $past(link_r) == LNK_L0)
        else $error("pme message outside L0");
    chk_pme_cold: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ20
        (dev_r == DEV_D3_COLD) |-> !pme_pend_r ##1 !pme_msg_out)
        else $error("pme in d3cold");
    chk_d3_sec_bus: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ21
        (dev_r == DEV_D3_HOT) && (link_r == LNK_L1) |=> (&secondary_clock_outputs_en_out)
        && secondary_bus_reset_n_out && !secondary_bus_enable_out)
        else $error("secondary bus wrong in d3hot");
    chk_l23_bus_off: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ22
        (link_r == LNK_L23) |=> !secondary_bus_enable_out && !pme_pend_r)
        else $error("secondary bus alive in L2/L3 ready");
    chk_d0_leaves_l1: assert property (@(posedge sys_clk_in) disable iff (!rst_n_in) // RQ23
        (link_r == LNK_L1) && d0_write && !power_removed_in |=> ##1 link_r == LNK_L1_EXIT)
        else $error("d0 write did not leave L1");
    cov_l0s: cover property (@(posedge sys_clk_in) link_r == LNK_L0S ##1 link_r == LNK_L0S_EXIT);
    cov_l1: cover property (@(posedge sys_clk_in) link_r == LNK_L1 ##1 link_r == LNK_L1_EXIT);
    cov_l23: cover property (@(posedge sys_clk_in) pme_to_ack_out);
    cov_pme: cover property (@(posedge sys_clk_in) pme_msg_out && dev_state_out == DEV_D3_HOT);
endmodule : pbpm_power_manager

// ===== pbpm_rc_model.sv
`timescale 1ns/1ns
// ==========================================================
// upstream partner: issues turn-off and l1 exit requests
module pbpm_rc_model (
    // clock and reset
    input wire logic sys_clk_in,
    input wire logic rst_n_in,
    // commands from the bench
    input wire logic turn_off_req_in,
    input wire logic l1_exit_req_in,
    // messages toward the bridge
    output logic pme_turn_off_out,
    output logic partner_l1_exit_out
);
    // launched just after the edge, one cycle wide; sends nothing else
    // while the link sleeps, so no packets in l1 or l2/l3 ready
    always_ff @(posedge sys_clk_in) begin
        pme_turn_off_out <= rst_n_in & turn_off_req_in;
        partner_l1_exit_out <= rst_n_in & l1_exit_req_in;
    end
endmodule : pbpm_rc_model

// ===== tb_top.sv
`timescale 1ns/1ns
module tb_top;
    import pbpm_pkg::*;
    // ==========================================================
    // stimulus, all changed at the falling edge
    logic clk = 1'b0, rst_n = 1'b0, ps_wr = 1'b0, mem_en = 1'b0, pwr_off = 1'b0;
    logic pend = 1'b0, rx_tlp = 1'b0, pci_req = 1'b0, pin_n = 1'b1;
    logic sent = 1'b0, io_en = 1'b0, bm_en = 1'b0;
    logic off_req = 1'b0, exit_req = 1'b0, rc_off, rc_exit;
    logic [1:0] ps_field = 2'h0, lse = 2'h0;
    // observed outputs
    pbpm_link_t link;
    pbpm_dev_t dev;
    logic no_soft, cfg_ok, tx_ok, rx_ok, pme_msg, ack, sec_rst_n, sec_en;
    logic [4:0] sec_clk;
    int err_total = 0, tests_run = 0;
    always #25 clk = ~clk;
    pbpm_rc_model rc (.sys_clk_in(clk), .rst_n_in(rst_n), .turn_off_req_in(off_req),
        .l1_exit_req_in(exit_req), .pme_turn_off_out(rc_off), .partner_l1_exit_out(rc_exit));
    // small sample period keeps the run short
    pbpm_power_manager #(.SEC_CLK_W(5), .PME_SAMPLE_CYC(20)) dut (
        .sys_clk_in(clk), .rst_n_in(rst_n), .power_state_field_in(ps_field),
        .power_state_wr_in(ps_wr), .link_standby_enable_field_in(lse),
        .mem_space_en_in(mem_en), .io_space_en_in(io_en), .bus_master_en_in(bm_en),
        .power_removed_in(pwr_off), .tx_pkt_pending_in(pend), .tx_pkt_sent_in(sent),
        .rx_tlp_in(rx_tlp), .pci_side_req_in(pci_req), .partner_l1_exit_in(rc_exit),
        .pme_turn_off_in(rc_off), .secondary_pme_request_n_in(pin_n),
        .link_state_out(link), .dev_state_out(dev), .no_soft_reset_out(no_soft),
        .config_accept_out(cfg_ok), .tx_allow_out(tx_ok), .rx_accept_out(rx_ok),
        .pme_msg_out(pme_msg), .pme_to_ack_out(ack), .secondary_clock_outputs_en_out(sec_clk),
        .secondary_bus_reset_n_out(sec_rst_n), .secondary_bus_enable_out(sec_en));
    // ==========================================================
    // shared helpers
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        tests_run++;
        if (got !== exp) begin
            err_total++;
            $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(negedge clk);
    endtask : cyc
    // bounded wait for a link state, then compare
    task automatic wait_link(input pbpm_link_t exp, input int bound);
        for (int n = 0; n < bound && link !== exp; n++) cyc(1);
        chk(8'(link), 8'(exp));
    endtask : wait_link
    task automatic wr_ps(input logic [1:0] f);
        cyc(1);
        ps_field = f;
        ps_wr = 1'b1;
        cyc(1);
        ps_wr = 1'b0;
    endtask : wr_ps
    // hold the pin active, count messages, link must be awake for each
    task automatic wait_pme(input int exp_n, input int bound);
        int seen;
        seen = 0;
        pin_n = 1'b0;
        repeat (bound) begin
            cyc(1);
            if (pme_msg === 1'b1) begin
                seen++;
                chk(8'(link), 8'(LNK_L0));
            end
        end
        pin_n = 1'b1;
        cyc(50); // sampler must see the pin idle before the next test
        chk(8'(seen), 8'(exp_n));
    endtask : wait_pme
    task automatic finish_test;
        $display("checks %0d mismatches %0d", tests_run, err_total);
        if (err_total == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : finish_test
    // ==========================================================
    // scenarios
    task automatic t_standby;
        chk(8'(dev), 8'(DEV_D0_UNINIT));
        mem_en = 1'b1;
        cyc(130);
        chk(8'(dev), 8'(DEV_D0_ACTIVE));
        chk(8'(link), 8'(LNK_L0));
        // idle count is already full: a pending packet restarts it as standby is enabled
        pend = 1'b1;
        lse = 2'h1;
        cyc(1);
        pend = 1'b0;
        // each wake source in turn, standby re-entered between them
        for (int i = 0; i < 3; i++) begin
            // a sent packet half way restarts the idle time
            cyc(60);
            sent = 1'b1;
            cyc(1);
            sent = 1'b0;
            cyc(115);
            chk(8'(link), 8'(LNK_L0));
            wait_link(LNK_L0S, 12);
            chk(8'({tx_ok, rx_ok}), 8'h01);
            {pend, rx_tlp, pci_req} = 3'h4 >> i;
            wait_link(LNK_L0S_EXIT, 3);
            wait_link(LNK_L0, 6);
            {pend, rx_tlp, pci_req} = 3'h0;
        end
        lse = 2'h0;
    endtask : t_standby
    task automatic t_d3;
        mem_en = 1'b0;
        wr_ps(PSF_D3HOT);
        cyc(2);
        chk(8'(dev), 8'(DEV_D3_HOT));
        wait_link(LNK_L1, 10);
        chk(8'({tx_ok, rx_ok, cfg_ok}), 8'h01);
        chk(8'({sec_clk, sec_rst_n, sec_en}), 8'h7E);
        exit_req = 1'b1;
        cyc(1);
        exit_req = 1'b0;
        wait_link(LNK_L1_EXIT, 4);
        wait_link(LNK_L0, 10);
        wait_link(LNK_L1, 12);
        wr_ps(PSF_D0);
        wait_link(LNK_L1_EXIT, 4);
        wait_link(LNK_L0, 10);
        chk(8'({dev, no_soft}), 8'h01);
        bm_en = 1'b1;
        cyc(2);
        chk(8'(dev), 8'(DEV_D0_ACTIVE));
        bm_en = 1'b0;
    endtask : t_d3
    task automatic t_off;
        wr_ps(PSF_D3HOT);
        wait_link(LNK_L1, 14);
        wait_pme(1, 80);
        wait_link(LNK_L1, 14);
        off_req = 1'b1;
        cyc(1);
        off_req = 1'b0;
        for (int n = 0; n < 30 && ack !== 1'b1; n++) cyc(1);
        chk(8'({ack, link}), 8'h0E);
        cyc(1);
        chk(8'({tx_ok, rx_ok, ack, sec_rst_n}), 8'h00);
        chk(8'(sec_clk), 8'h00);
        wait_pme(0, 80);
    endtask : t_off
    task automatic t_cold;
        rst_n = 1'b0;
        cyc(8);
        rst_n = 1'b1;
        io_en = 1'b1;
        cyc(3);
        chk(8'(dev), 8'(DEV_D0_ACTIVE));
        io_en = 1'b0;
        pwr_off = 1'b1;
        cyc(3);
        chk(8'(dev), 8'(DEV_D3_COLD));
        wait_pme(0, 80);
    endtask : t_cold
    initial begin
        cyc(8);
        rst_n = 1'b1;
        t_standby();
        t_d3();
        t_off();
        t_cold();
        finish_test();
    end
    // watchdog, about five times the expected run
    initial begin
        cyc(6000);
        err_total++;
        finish_test();
    end
endmodule : tb_top
